// [rtl/dwt_pkg.sv]
// Constants and types shared by the disk write and track select logic.
// Assumes a 200 MHz pclk; disk pulses arrive as one-cycle synchronous strobes.
// Notes on behaviour
// - Write start sets write direction and starts the normal track search.
// - Write start raises a break request; address-accepted pulse clears it.
// - Confirmed address in write direction enables head current and shift pulses.
// - Each shift moves MSB out; a one toggles the writer, twelve bits per word.
// - Loading the buffer sets the input bit, marker one enters first, then zeros.
// - Marker at top blocks toggling; final shift clears writer for even parity.
// - After overflow, word end sets transfer complete instead of a break request.
// - Extended bits 2, 1 and 0 pick a head pair; bit 3 picks one.
// - Lockout is OR of locked unit lines, ANDed with write, split by bit 3.
// - In-track address wraps to zero; search end with carry steps the track.
// - Carry out of extended bit 3 steps the unit number bits.
// - Bits 4 and 5 decode to four unit lines; matching switch selects unit.
// - Selected unit returns timing and data pulses; control drives its writer.
// - Carry into next unit clears memory request and sets request sync.
// - Late error when a break request is still pending at next word end.
// - Parity, late and lock flags are readable through the error-test code.
// - Writes into a locked half of the base unit set low or high flags.
// - Expander lock flag combines low and high flags of every expander.
// - Each word end raises a break request for the next word unless overflow.
// - Track address is incremented with a held carry during recirculation.
package dwt_pkg;
  localparam int WORD_W = 12;
  localparam int TRACK_W = 11;
  localparam int EXT_W = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WC = 8'h08;
  localparam logic [7:0] OFS_SW = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // Instruction codes written to the command register
  localparam logic [11:0] CODE_WRITE = 12'hC85;
  localparam logic [11:0] CODE_READ = 12'hC83;
  localparam logic [11:0] CODE_ERRTEST = 12'hD91; // Octal 6621
  // Field positions
  localparam int ADDR_EXT_LSB = 11;
  localparam int SW_LOW_BIT = 4;
  localparam int SW_HIGH_BIT = 5;
  localparam int SW_UNIT_LSB = 6;
  localparam int EXT_HALF_BIT = 3;
  localparam logic [TRACK_W-1:0] TRACK_MAX = 11'h7FF; // Octal 3777
  localparam logic [3:0] EXT_LOW_FULL = 4'hF;
  localparam logic [2:0] SYNC_PULSES = 3'h4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic skip;
    logic xfer_done;
    logic exp_lock;
    logic lock_high;
    logic lock_low;
    logic late;
    logic parity;
  } dwt_err_t;

  typedef struct packed {
    logic [7:0] head_pair;
    logic head_upper;
    logic [3:0] unit_line;
    logic unit_hit;
    logic lock_low;
    logic lock_high;
  } dwt_head_t;
endpackage

// [rtl/dwt_shifter.sv]
// Write data shift buffer with marker bit and write toggle.
// Assumes load and shift never coincide; shift comes only after address confirm.
`timescale 1ns/1ps
`default_nettype none
module dwt_shifter #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load_buffer_pulse,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift_data_pulse,
  // Status
  output logic msb_out,
  output logic marker_reached,
  output logic write_toggle
);
  logic [WIDTH-1:0] buf_reg, buf_next;
  logic bib_reg, bib_next;
  logic tog_reg, tog_next;

  initial if (WIDTH < 2) $error("dwt_shifter: WIDTH too small");

  // Marker sits at the top only when all lower bits and input bit are zero
  assign marker_reached = (buf_reg[WIDTH-2:0] == '0) && !bib_reg;
  assign msb_out = buf_reg[WIDTH-1];
  assign write_toggle = tog_reg;

  // Next state of buffer, input bit and writer
  always_comb
  begin
    buf_next = buf_reg;
    bib_next = bib_reg;
    tog_next = tog_reg;
    if (load_buffer_pulse)
    begin
      buf_next = load_data;
      bib_next = 1'b1;
    end
    else if (shift_data_pulse)
    begin
      buf_next = {buf_reg[WIDTH-2:0], bib_reg};
      bib_next = 1'b0;
      if (marker_reached)
        tog_next = 1'b0;
      else if (msb_out)
        tog_next = !tog_reg;
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_reg <= '0;
      bib_reg <= 1'b0;
      tog_reg <= 1'b0;
    end
    else
    begin
      buf_reg <= buf_next;
      bib_reg <= bib_next;
      tog_reg <= tog_next;
    end
  end
endmodule // dwt_shifter
`default_nettype wire

// [rtl/dwt_head_sel.sv]
// Head, unit and write lock decode; purely combinational.
// Assumes switch settings are static during a transfer.
`timescale 1ns/1ps
`default_nettype none
module dwt_head_sel (
  // Address and direction
  input wire logic [dwt_pkg::EXT_W-1:0] ext_addr,
  input wire logic write_dir,
  // Switch settings
  input wire logic [3:0] lock_sel,
  input wire logic lock_low_en,
  input wire logic lock_high_en,
  input wire logic [1:0] unit_switch,
  // Decode result
  output dwt_pkg::dwt_head_t head
);
  logic write_lockout;
  logic [1:0] unit_num;
  logic [3:0] unit_line;

  assign unit_num = ext_addr[5:4];
  // Unit lines decoded apart, so the lockout OR does not loop through the output struct
  always_comb
  begin
    unit_line = 4'h0;
    unit_line[unit_num] = 1'b1;
  end

  // One-hot pair from extended bits 2, 1 and 0
  always_comb
  begin
    head.head_pair = 8'h00;
    head.head_pair[ext_addr[2:0]] = 1'b1;
    head.head_upper = ext_addr[dwt_pkg::EXT_HALF_BIT];
    head.unit_line = unit_line;
    head.unit_hit = (unit_num == unit_switch);
    head.lock_low = write_lockout && lock_low_en && !ext_addr[dwt_pkg::EXT_HALF_BIT];
    head.lock_high = write_lockout && lock_high_en && ext_addr[dwt_pkg::EXT_HALF_BIT];
  end

  // Lockout applies only to units the selector picked, and only when writing
  assign write_lockout = |(unit_line & lock_sel) && write_dir;
endmodule // dwt_head_sel
`default_nettype wire

// [rtl/dwt_ctrl.sv]
// Disk write path, track stepping, unit carry and error flags, with APB registers.
// Assumes disk pulses and break strobes are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module dwt_ctrl #(
  parameter int WORD_W = dwt_pkg::WORD_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host break facility
  output logic break_request,
  output logic write_dir,
  input wire logic brk_addr_accept,
  input wire logic brk_load,
  input wire logic [WORD_W-1:0] brk_data,
  // Search logic and timing
  input wire logic addr_confirm,
  input wire logic search_active,
  input wire logic word_end_pulse,
  input wire logic timing_track_pulse,
  input wire logic read_parity_fail,
  output logic search_start,
  output logic memory_request,
  // Selected unit
  output logic head_current_enable,
  output logic write_toggle,
  output logic [7:0] head_pair,
  output logic head_upper,
  output logic [3:0] unit_select_line,
  // Expanders and completion
  input wire logic [2:0] exp_lock_low,
  input wire logic [2:0] exp_lock_high,
  output logic transfer_complete
);
  initial if (WORD_W != dwt_pkg::WORD_W) $error("dwt_ctrl: WORD_W must match package");

  logic wr_cycle, rd_cycle;
  logic cmd_write, cmd_read, cmd_err;
  logic shift_data_pulse, msb_out, marker_reached;
  logic sad_fall, ext_carry;
  dwt_pkg::dwt_head_t head;
  dwt_pkg::dwt_err_t err_reg, err_next;
  logic [dwt_pkg::TRACK_W-1:0] track_reg, track_next;
  logic [dwt_pkg::EXT_W-1:0] ext_reg, ext_next;
  logic [WORD_W-1:0] wc_reg, wc_next;
  logic [7:0] sw_reg, sw_next;
  logic ovf_reg, ovf_next;
  logic dir_reg, dir_next;
  logic brk_reg, brk_next;
  logic carry_reg, carry_next;
  logic sad_reg, sad_next;
  logic mreq_reg, mreq_next;
  logic rsync_reg, rsync_next;
  logic [2:0] tcnt_reg, tcnt_next;
  logic [31:0] rdata_reg, rdata_next;

  // APB decode; slave always answers in the access cycle
  assign wr_cycle = psel && penable && pwrite;
  assign rd_cycle = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == dwt_pkg::OFS_CMD || paddr == dwt_pkg::OFS_ADDR ||
    paddr == dwt_pkg::OFS_WC || paddr == dwt_pkg::OFS_SW || paddr == dwt_pkg::OFS_STAT);
  assign cmd_write = wr_cycle && paddr == dwt_pkg::OFS_CMD && pwdata[11:0] == dwt_pkg::CODE_WRITE;
  assign cmd_read = wr_cycle && paddr == dwt_pkg::OFS_CMD && pwdata[11:0] == dwt_pkg::CODE_READ;
  assign cmd_err = wr_cycle && paddr == dwt_pkg::OFS_CMD && pwdata[11:0] == dwt_pkg::CODE_ERRTEST;
  assign prdata = rdata_reg;

  // Head current only on a confirmed address, writing, and not locked
  assign head_current_enable = addr_confirm && dir_reg && head.unit_hit &&
    !head.lock_low && !head.lock_high;
  assign shift_data_pulse = head_current_enable && timing_track_pulse;
  assign sad_fall = sad_reg && !search_active;
  assign ext_carry = ext_reg[3:0] == dwt_pkg::EXT_LOW_FULL;

  // Port copies of state, plus the search start strobe
  assign break_request = brk_reg;
  assign write_dir = dir_reg;
  assign search_start = cmd_write || cmd_read;
  assign memory_request = mreq_reg;
  assign transfer_complete = err_reg.xfer_done;
  assign head_pair = head.head_pair;
  assign head_upper = head.head_upper;
  assign unit_select_line = head.unit_line;

  dwt_shifter #(
    .WIDTH(WORD_W)
  ) u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .load_buffer_pulse(brk_load && dir_reg),
    .load_data(brk_data),
    .shift_data_pulse(shift_data_pulse),
    .msb_out(msb_out),
    .marker_reached(marker_reached),
    .write_toggle(write_toggle)
  );

  dwt_head_sel u_head_sel (
    .ext_addr(ext_reg),
    .write_dir(dir_reg),
    .lock_sel(sw_reg[3:0]),
    .lock_low_en(sw_reg[dwt_pkg::SW_LOW_BIT]),
    .lock_high_en(sw_reg[dwt_pkg::SW_HIGH_BIT]),
    .unit_switch(sw_reg[dwt_pkg::SW_UNIT_LSB +: 2]),
    .head(head)
  );

  // Transfer control, addressing and registers: next values
  always_comb
  begin
    track_next = track_reg;
    ext_next = ext_reg;
    wc_next = wc_reg;
    sw_next = sw_reg;
    ovf_next = ovf_reg;
    dir_next = dir_reg;
    brk_next = brk_reg;
    carry_next = carry_reg;
    sad_next = search_active;
    mreq_next = mreq_reg;
    rsync_next = rsync_reg;
    tcnt_next = tcnt_reg;
    err_next = err_reg;
    rdata_next = dwt_pkg::RESET_WORD;
    // Software writes come first so hardware events below win over them
    if (wr_cycle)
    begin
      case (paddr)
        dwt_pkg::OFS_ADDR:
        begin
          track_next = pwdata[dwt_pkg::TRACK_W-1:0];
          ext_next = pwdata[dwt_pkg::ADDR_EXT_LSB +: dwt_pkg::EXT_W];
        end
        dwt_pkg::OFS_WC: wc_next = pwdata[WORD_W-1:0];
        dwt_pkg::OFS_SW: sw_next = pwdata[7:0];
        dwt_pkg::OFS_STAT: err_next = err_reg & ~pwdata[6:0]; // Write one to clear
        default: ;
      endcase
    end
    if (cmd_write || cmd_read)
    begin
      dir_next = cmd_write;
      ovf_next = 1'b0;
      rsync_next = 1'b1;
      mreq_next = 1'b0;
      tcnt_next = 3'h0;
      err_next.xfer_done = 1'b0;
    end
    if (cmd_err)
      err_next.skip = err_reg.parity || err_reg.late || err_reg.lock_low ||
        err_reg.lock_high || err_reg.exp_lock;
    // Request sync waits a few timing pulses before memory request
    if (rsync_reg && timing_track_pulse)
    begin
      if (tcnt_reg == dwt_pkg::SYNC_PULSES - 3'h1)
      begin
        rsync_next = 1'b0;
        mreq_next = 1'b1;
      end
      else
        tcnt_next = tcnt_reg + 3'h1;
    end
    // Accepted address clears the request and counts the word
    if (brk_addr_accept)
    begin
      brk_next = 1'b0;
      wc_next = wc_reg - {{(WORD_W-1){1'b0}}, 1'b1};
      if (wc_reg == {{(WORD_W-1){1'b0}}, 1'b1})
        ovf_next = 1'b1;
    end
    if (cmd_write)
      brk_next = 1'b1;
    if (word_end_pulse)
    begin
      if (brk_reg)
        err_next.late = 1'b1;
      if (ovf_reg)
        err_next.xfer_done = 1'b1;
      else
      begin
        brk_next = 1'b1;
        track_next = track_reg + {{(dwt_pkg::TRACK_W-1){1'b0}}, 1'b1};
        carry_next = (track_reg == dwt_pkg::TRACK_MAX);
      end
    end
    // Search end with a held carry steps track, then unit
    if (sad_fall && carry_reg)
    begin
      ext_next = ext_reg + {{(dwt_pkg::EXT_W-1){1'b0}}, 1'b1};
      carry_next = 1'b0;
      if (ext_carry)
      begin
        mreq_next = 1'b0;
        rsync_next = 1'b1;
        tcnt_next = 3'h0;
      end
    end
    if (read_parity_fail)
      err_next.parity = 1'b1;
    if (head_current_enable || (addr_confirm && dir_reg && head.unit_hit))
    begin
      if (head.lock_low)
        err_next.lock_low = 1'b1;
      if (head.lock_high)
        err_next.lock_high = 1'b1;
    end
    if (|{exp_lock_low, exp_lock_high})
      err_next.exp_lock = 1'b1;
    // Read data, registered for the access phase
    if (rd_cycle)
    begin
      case (paddr)
        dwt_pkg::OFS_ADDR: rdata_next = {15'h0000, ext_reg, track_reg};
        dwt_pkg::OFS_WC: rdata_next = {20'h00000, wc_reg};
        dwt_pkg::OFS_SW: rdata_next = {24'h000000, sw_reg};
        dwt_pkg::OFS_STAT: rdata_next = {19'h00000, ovf_reg, rsync_reg, mreq_reg, carry_reg,
          dir_reg, brk_reg, err_reg};
        default: rdata_next = dwt_pkg::RESET_WORD;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      track_reg <= '0;
      ext_reg <= '0;
      wc_reg <= '0;
      sw_reg <= 8'h00;
      ovf_reg <= 1'b0;
      dir_reg <= 1'b0;
      brk_reg <= 1'b0;
      carry_reg <= 1'b0;
      sad_reg <= 1'b0;
      mreq_reg <= 1'b0;
      rsync_reg <= 1'b0;
      tcnt_reg <= 3'h0;
      err_reg <= '0;
      rdata_reg <= dwt_pkg::RESET_WORD;
    end
    else
    begin
      track_reg <= track_next;
      ext_reg <= ext_next;
      wc_reg <= wc_next;
      sw_reg <= sw_next;
      ovf_reg <= ovf_next;
      dir_reg <= dir_next;
      brk_reg <= brk_next;
      carry_reg <= carry_next;
      sad_reg <= sad_next;
      mreq_reg <= mreq_next;
      rsync_reg <= rsync_next;
      tcnt_reg <= tcnt_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_last_word;
    word_end_pulse && ovf_reg;
  endsequence

  sequence s_unit_carry;
    sad_fall && carry_reg && ext_carry;
  endsequence

  sequence s_load;
    brk_load && dir_reg;
  endsequence

  sequence s_sync_done;
    rsync_reg && timing_track_pulse && tcnt_reg == dwt_pkg::SYNC_PULSES - 3'h1;
  endsequence

  sequence s_track_wrap;
    word_end_pulse && !ovf_reg && track_reg == dwt_pkg::TRACK_MAX;
  endsequence

  write_dir_set_a: assert property (cmd_write |=> dir_reg && brk_reg)
    else $error("write start did not set direction and request");
  break_clear_a: assert property (brk_addr_accept && !cmd_write && !word_end_pulse |=> !brk_reg)
    else $error("address accept did not clear break request");
  head_enable_a: assert property (head_current_enable |-> addr_confirm && dir_reg)
    else $error("head current without write confirm");
  toggle_one_a: assert property (shift_data_pulse && !marker_reached && msb_out
    |=> write_toggle != $past(write_toggle))
    else $error("one bit did not toggle writer");
  parity_clear_a: assert property (shift_data_pulse && marker_reached |=> !write_toggle)
    else $error("final shift did not clear writer");
  complete_set_a: assert property (s_last_word |=> transfer_complete)
    else $error("last word end did not flag completion");
  late_flag_a: assert property (word_end_pulse && brk_reg |=> err_reg.late)
    else $error("pending request not flagged late");
  unit_resync_a: assert property ((s_unit_carry and (!cmd_write && !cmd_read)) |=>
    !mreq_reg && rsync_reg && ext_reg == $past(ext_reg) + 6'h01)
    else $error("unit carry did not resynchronise");
  next_word_a: assert property (word_end_pulse && !ovf_reg |=> brk_reg)
    else $error("word end did not request next word");

  // A fresh load must hide the marker until the word has been shifted out
  marker_load_a: assert property (s_load |=> !marker_reached)
    else $error("load left the marker condition set");

  // Sync count finishes unless a unit carry or a new start restarts it
  sync_request_a: assert property ((s_sync_done and (!(sad_fall && carry_reg && ext_carry) &&
    !cmd_write && !cmd_read)) |=> memory_request && !rsync_reg)
    else $error("sync count did not raise memory request");

  // The wrap of the in-track address is what arms the track step
  track_wrap_a: assert property ((s_track_wrap and !sad_fall) |=> carry_reg && track_reg == '0)
    else $error("address wrap did not hold the carry");
  track_step_a: assert property (sad_fall && carry_reg |=>
    !carry_reg && ext_reg == $past(ext_reg) + 6'h01)
    else $error("held carry did not step the track");

  // Error flags; a hardware set beats a software clear in the same cycle
  lock_flag_a: assert property (addr_confirm && dir_reg && head.unit_hit && head.lock_low |=>
    err_reg.lock_low)
    else $error("low half write not flagged");
  exp_lock_a: assert property (|{exp_lock_low, exp_lock_high} |=> err_reg.exp_lock)
    else $error("expander lock not flagged");
  skip_test_a: assert property (cmd_err && err_reg.late |=> err_reg.skip)
    else $error("error test missed a late error");
endmodule // dwt_ctrl
`default_nettype wire

// [verif/dwt_host_model.sv]
// Host data-break model: answers each write-direction break request with a word load, then an accept.
// Assumes dwt_ctrl on the other side; stall holds off service so a late request can occur.
`timescale 1ns/1ps
`default_nettype none
module dwt_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device side
  input wire logic break_request,
  input wire logic write_dir,
  input wire logic stall,
  output logic brk_load,
  output logic brk_addr_accept,
  output logic [11:0] brk_data
);
  logic [1:0] step_reg;
  logic [11:0] word_reg;
  // Outside the load strobe the lines show the inverse, so a stale copy cannot pass
  assign brk_data = brk_load ? word_reg : ~word_reg;
  // Load, accept, then idle two cycles and step the word before serving again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_reg <= 2'h0;
      brk_load <= 1'b0;
      brk_addr_accept <= 1'b0;
      word_reg <= 12'hA53;
    end
    else
    begin
      brk_load <= 1'b0;
      brk_addr_accept <= 1'b0;
      case (step_reg)
        2'h0: if (break_request && write_dir && !stall) {step_reg, brk_load} <= {2'h1, 1'b1};
        2'h1: {step_reg, brk_addr_accept} <= {2'h2, 1'b1};
        2'h2: step_reg <= 2'h3;
        default:
        begin
          step_reg <= 2'h0;
          word_reg <= word_reg + 12'h3C1;
        end
      endcase
    end
  end
endmodule // dwt_host_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for dwt_ctrl, with the host break model on its far side.
// Assumes zero-wait APB, the dwt_ctrl register layout and one-cycle disk strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, err, t;
  logic [7:0] paddr, head_pair;
  logic [31:0] pwdata, prdata, rdata;
  logic break_request, write_dir, brk_addr_accept, brk_load, search_start, memory_request;
  logic addr_confirm, search_active, word_end_pulse, timing_track_pulse, read_parity_fail;
  logic head_current_enable, write_toggle, head_upper, transfer_complete;
  logic [11:0] brk_data;
  logic [3:0] unit_select_line;
  logic [2:0] exp_lock_low, exp_lock_high;
  logic [5:0] e;
  int failures, checked, cycles, starts;

  dwt_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .break_request(break_request), .write_dir(write_dir), .brk_addr_accept(brk_addr_accept),
    .brk_load(brk_load), .brk_data(brk_data), .addr_confirm(addr_confirm), .search_active(search_active),
    .word_end_pulse(word_end_pulse), .timing_track_pulse(timing_track_pulse),
    .read_parity_fail(read_parity_fail), .search_start(search_start), .memory_request(memory_request),
    .head_current_enable(head_current_enable), .write_toggle(write_toggle), .head_pair(head_pair),
    .head_upper(head_upper), .unit_select_line(unit_select_line), .exp_lock_low(exp_lock_low),
    .exp_lock_high(exp_lock_high), .transfer_complete(transfer_complete));

  dwt_host_model host (.pclk(pclk), .presetn(presetn), .break_request(break_request),
    .write_dir(write_dir), .stall(stall), .brk_load(brk_load), .brk_addr_accept(brk_addr_accept),
    .brk_data(brk_data));

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      stop_test();
    end
  end

  // Every write or read start must show exactly one search start strobe
  always @(posedge pclk)
    if (search_start === 1'b1)
      starts++;

  task stop_test();
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle();
    @(posedge pclk);
    #1;
  endtask

  // One-cycle strobes: bit 0 timing, bit 1 word end, bit 2 parity fail
  task strobe(input logic [2:0] m);
    @(posedge pclk);
    {read_parity_fail, word_end_pulse, timing_track_pulse} <= m;
    @(posedge pclk);
    {read_parity_fail, word_end_pulse, timing_track_pulse} <= 3'h0;
    #1;
  endtask

  // Thirteen shifts: data bits MSB first, then the parity slot clears the writer
  task write_word(input logic [11:0] w);
    @(posedge pclk);
    addr_confirm <= 1'b1;
    t = 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      strobe(3'h1);
      t = (i < 12) ? t ^ w[11 - i] : 1'b0;
      `CHK("write_toggle", t, write_toggle)
    end
    `CHK("head_enable", 1'b1, head_current_enable)
    @(posedge pclk);
    addr_confirm <= 1'b0;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, addr_confirm, search_active} = 6'h00;
    {word_end_pulse, timing_track_pulse, read_parity_fail} = 3'h0;
    {paddr, pwdata, exp_lock_low, exp_lock_high, stall} = {8'h00, 32'h0, 3'h0, 3'h0, 1'b1};
    failures = 0;
    checked = 0;
    cycles = 0;
    starts = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK("reset_outputs", 3'h0, {write_toggle, break_request, transfer_complete})
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("reset_status", 32'h0, rdata)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rdata})
    // Every extended address: head pair, half and unit line
    for (int i = 0; i < 64; i++)
    begin
      e = i[5:0];
      apb(1'b1, dwt_pkg::OFS_ADDR, {15'h0, e, 11'h000});
      settle();
      `CHK("head_pair", 8'h01 << e[2:0], head_pair)
      `CHK("head_upper", e[3], head_upper)
      `CHK("unit_line", 4'h1 << e[5:4], unit_select_line)
    end
    // Two-word write, host held off until the memory request is seen
    apb(1'b1, dwt_pkg::OFS_SW, 32'h0);
    apb(1'b1, dwt_pkg::OFS_ADDR, 32'h0);
    apb(1'b1, dwt_pkg::OFS_WC, 32'h2);
    apb(1'b1, dwt_pkg::OFS_CMD, {20'h0, dwt_pkg::CODE_WRITE});
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("start_state", 6'h13, rdata[12:7])
    repeat (4) strobe(3'h1);
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("mem_request", 1'b1, rdata[10])
    stall <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("brk_cleared", 1'b0, rdata[7])
    write_word(12'hA53);
    strobe(3'h2);
    `CHK("brk_again", 1'b1, break_request)
    repeat (8) @(posedge pclk);
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("overflow", 2'h2, {rdata[12], rdata[7]})
    write_word(12'hE14);
    strobe(3'h2);
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("complete", 4'h5, {rdata[7], rdata[5], rdata[1], transfer_complete})
    // Unserved request at word end, then the error-test code
    stall <= 1'b1;
    apb(1'b1, dwt_pkg::OFS_WC, 32'h1);
    apb(1'b1, dwt_pkg::OFS_CMD, {20'h0, dwt_pkg::CODE_WRITE});
    strobe(3'h2);
    strobe(3'h4);
    apb(1'b1, dwt_pkg::OFS_CMD, {20'h0, dwt_pkg::CODE_ERRTEST});
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("errors", 3'h7, {rdata[6], rdata[1], rdata[0]})
    apb(1'b1, dwt_pkg::OFS_STAT, 32'h7F);
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("cleared", 7'h00, rdata[6:0])
    // Lock halves of this unit, and expander flags
    apb(1'b1, dwt_pkg::OFS_SW, 32'h11);
    apb(1'b1, dwt_pkg::OFS_ADDR, 32'h0);
    addr_confirm <= 1'b1;
    settle();
    `CHK("low_blocked", 1'b0, head_current_enable)
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("lock_low", 1'b1, rdata[2])
    apb(1'b1, dwt_pkg::OFS_ADDR, 32'h4000);
    settle();
    `CHK("upper_free", 1'b1, head_current_enable)
    apb(1'b1, dwt_pkg::OFS_SW, 32'h21);
    settle();
    `CHK("upper_blocked", 1'b0, head_current_enable)
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("lock_high", 1'b1, rdata[3])
    exp_lock_high <= 3'h2;
    apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
    `CHK("exp_lock", 1'b1, rdata[4])
    apb(1'b1, dwt_pkg::OFS_SW, 32'h0);
    apb(1'b1, dwt_pkg::OFS_CMD, {20'h0, dwt_pkg::CODE_READ});
    settle();
    `CHK("read_no_current", 2'h0, {write_dir, head_current_enable})
    @(posedge pclk);
    addr_confirm <= 1'b0;
    exp_lock_high <= 3'h0;
    // Track wrap, plain and into the next unit
    for (int k = 0; k < 2; k++)
    begin
      e = k ? 6'h0F : 6'h00;
      apb(1'b1, dwt_pkg::OFS_ADDR, {15'h0, e, 11'h7FF});
      apb(1'b1, dwt_pkg::OFS_CMD, {20'h0, dwt_pkg::CODE_WRITE});
      repeat (4) strobe(3'h1);
      strobe(3'h2);
      apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
      `CHK("carry_hold", 1'b1, rdata[9])
      search_active <= 1'b1;
      @(posedge pclk);
      search_active <= 1'b0;
      settle();
      settle();
      `CHK("next_pair", k ? 8'h01 : 8'h02, head_pair)
      `CHK("next_unit", k ? 4'h2 : 4'h1, unit_select_line)
      apb(1'b0, dwt_pkg::OFS_STAT, 32'h0);
      `CHK("mem_req", ~k[0], rdata[10])
      `CHK("mem_port", ~k[0], memory_request)
      if (k == 1)
        `CHK("resync", 1'b1, rdata[11])
    end
    `CHK("search_starts", 5, starts)
    stop_test();
  end
endmodule // testbench
`default_nettype wire
